// >>> rtl/xcvr_status_regs.sv
// status and mode register group of the line transceiver
// assumes a synchronous single-cycle register port on sys_clk, monitors asynchronous
`timescale 1ns/1ps
module xcvr_status_regs
	import xcvr_status_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic line_pin,
	input wire logic aux_pin,
	input wire logic drv_fault_in,
	input wire logic sup_warn_in,
	input wire logic sup_uv_in,
	input wire logic therm_sd_in,
	input wire logic therm_warn_in,
	input wire logic corrupt_in,
	output logic line_drv_en,
	output logic rx_oe,
	output logic line_indicator_output_oe,
	output logic reg33_force_on,
	output logic clk_out_en,
	output logic clk_out,
	output logic soft_reset_pulse
);
	monitor_t mon_raw;
	monitor_t mon_s;
	logic [7:0] live_status;
	logic [7:0] integrity_q;
	logic sw_reset_q;
	logic [7:0] rdata_d;
	logic clk_div_q;

	assign mon_raw = '{line_low: ~line_pin, aux_low: ~aux_pin, drv_fault: drv_fault_in,
		sup_warn: sup_warn_in, sup_uv: sup_uv_in, therm_sd: therm_sd_in,
		therm_warn: therm_warn_in, corrupt: corrupt_in};

	mon_sync u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.async_in(mon_raw),
		.sync_out(mon_s)
	);

	// ****************************************
	// live status assembly
	// ****************************************
	always_comb begin
		live_status = 8'h00;
		live_status[LINE_LVL_BIT] = mon_s.line_low;
		live_status[AUX_LVL_BIT] = mon_s.aux_low;
		live_status[DRV_FAULT_BIT] = mon_s.drv_fault;
		live_status[SUP_WARN_BIT] = mon_s.sup_warn;
		live_status[SUP_UV_BIT] = mon_s.sup_uv;
		live_status[THERM_SD_BIT] = mon_s.therm_sd;
		live_status[THERM_WARN_BIT] = mon_s.therm_warn;
	end

	// ****************************************
	// software reset, self clearing
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sw_reset_q <= 1'b0;
		end else if (sw_reset_q) begin
			sw_reset_q <= 1'b0;
		end else begin
			sw_reset_q <= reg_wr && reg_addr == SW_RESET_CTRL_OFS
				&& reg_wdata[SW_RESET_BIT];
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			soft_reset_pulse <= 1'b0;
		end else begin
			soft_reset_pulse <= sw_reset_q;
		end
	end

	// ****************************************
	// integrity flag
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			integrity_q <= INTEGRITY_RESET;
		end else if (mon_s.corrupt) begin
			integrity_q[CORRUPT_BIT] <= 1'b1;
		end else if (sw_reset_q) begin
			integrity_q <= INTEGRITY_RESET;
		end else begin
			integrity_q[CORRUPT_BIT] <= 1'b0;
		end
	end

	// ****************************************
	// read port; mode register reads zero
	// ****************************************
	always_comb begin
		rdata_d = 8'h00;
		unique case (reg_addr)
			LIVE_STATUS_OFS: rdata_d = live_status;
			INTEGRITY_STATUS_OFS: rdata_d = integrity_q;
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= RDATA_RESET;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	// ****************************************
	// corruption overrides
	// ****************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			line_drv_en <= 1'b1;
			rx_oe <= 1'b1;
			line_indicator_output_oe <= 1'b1;
			reg33_force_on <= 1'b0;
			clk_out_en <= 1'b0;
		end else begin
			line_drv_en <= ~integrity_q[CORRUPT_BIT];
			rx_oe <= ~integrity_q[CORRUPT_BIT];
			line_indicator_output_oe <= ~integrity_q[CORRUPT_BIT];
			reg33_force_on <= integrity_q[CORRUPT_BIT];
			clk_out_en <= integrity_q[CORRUPT_BIT];
		end
	end

	// clock output toggles each cycle while enabled, stands low otherwise
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_div_q <= 1'b0;
			clk_out <= 1'b0;
		end else begin
			clk_div_q <= integrity_q[CORRUPT_BIT] ? ~clk_div_q : 1'b0;
			clk_out <= clk_div_q;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence reset_write_s;
		reg_wr && reg_addr == SW_RESET_CTRL_OFS && reg_wdata[SW_RESET_BIT] && !sw_reset_q;
	endsequence

	chk_sw_reset_once: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reset_write_s |=> sw_reset_q ##1 !sw_reset_q)
		else $error("software reset not a single pulse");
	chk_sw_reset_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sw_reset_q |=> !sw_reset_q)
		else $error("software reset bit stuck");
	chk_mode_reads_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == SW_RESET_CTRL_OFS |=> reg_rdata == 8'h00)
		else $error("mode register readable");
	chk_fault_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == LIVE_STATUS_OFS |=> reg_rdata[DRV_FAULT_BIT] == $past(mon_s.drv_fault))
		else $error("driver fault bit wrong");
	chk_warn_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == LIVE_STATUS_OFS |=> reg_rdata[SUP_WARN_BIT] == $past(mon_s.sup_warn))
		else $error("supply warning bit wrong");
	chk_therm_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == LIVE_STATUS_OFS |=> reg_rdata[THERM_SD_BIT] == $past(mon_s.therm_sd))
		else $error("thermal shutdown bit wrong");
	chk_level_inv: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == LIVE_STATUS_OFS |=> reg_rdata[LINE_LVL_BIT] == $past(mon_s.line_low)
		&& reg_rdata[AUX_LVL_BIT] == $past(mon_s.aux_low))
		else $error("level bits not inverted");
	chk_corrupt_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
		integrity_q[CORRUPT_BIT] |=> !line_drv_en && !rx_oe && !line_indicator_output_oe)
		else $error("outputs active while corrupted");
	chk_corrupt_clk: assert property (@(posedge sys_clk) disable iff (sys_rst)
		integrity_q[CORRUPT_BIT] [*4] |=> reg33_force_on && clk_out != $past(clk_out))
		else $error("clock output not toggling");

	// ****************************************
	// checks on reads, reset pulse and corruption path
	// ****************************************
	sequence clean_held_s;
		(!integrity_q[CORRUPT_BIT]) [*2];
	endsequence

	chk_reset_needs_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(reg_wr && reg_addr == SW_RESET_CTRL_OFS && reg_wdata[SW_RESET_BIT]) |=> !sw_reset_q)
		else $error("software reset without a reset write");
	chk_pulse_follow: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sw_reset_q |=> soft_reset_pulse && !sw_reset_q)
		else $error("reset pulse missing");
	chk_pulse_single: assert property (@(posedge sys_clk) disable iff (sys_rst)
		soft_reset_pulse |=> !soft_reset_pulse)
		else $error("reset pulse longer than one cycle");
	chk_integrity_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == INTEGRITY_STATUS_OFS |=> reg_rdata == $past(integrity_q))
		else $error("integrity register read wrong");
	chk_corrupt_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
		mon_s.corrupt |=> integrity_q[CORRUPT_BIT])
		else $error("corruption flag not set");
	chk_corrupt_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!mon_s.corrupt |=> !integrity_q[CORRUPT_BIT])
		else $error("corruption flag not cleared");
	chk_outputs_restore: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!integrity_q[CORRUPT_BIT] |=> line_drv_en && rx_oe && line_indicator_output_oe
		&& !reg33_force_on && !clk_out_en)
		else $error("overrides active without corruption");
	chk_clk_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
		clean_held_s |=> !clk_out)
		else $error("clock output running without corruption");
	chk_rdata_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	chk_live_other: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == LIVE_STATUS_OFS |=> reg_rdata[SUP_UV_BIT] == $past(mon_s.sup_uv)
		&& reg_rdata[THERM_WARN_BIT] == $past(mon_s.therm_warn))
		else $error("undervoltage or thermal warning bit wrong");
	chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr != LIVE_STATUS_OFS && reg_addr != INTEGRITY_STATUS_OFS
		|=> reg_rdata == 8'h00)
		else $error("unmapped offset reads nonzero");
endmodule : xcvr_status_regs

// >>> rtl/xcvr_status_pkg.sv
// constants and carrier types for the transceiver status and mode register group
// assumes a single 100 MHz clock and an 8-bit register port with 8-bit offsets
// Functional notes
// - supply warning bit 3 reads one while supply below warning threshold
// - thermal shutdown bit 1 reads one while die above shutdown threshold
// - corruption flag bit 7 of integrity status disables driver, tristates outputs
// - corruption forces regulator on and clock output toggling every sys_clk cycle, at half the sys_clk rate
// - software reset bit clears itself after the reset is applied; write only
package xcvr_status_pkg;
	localparam logic [7:0] LIVE_STATUS_OFS = 8'h02;
	localparam logic [7:0] INTEGRITY_STATUS_OFS = 8'h03;
	localparam logic [7:0] SW_RESET_CTRL_OFS = 8'h04;
	localparam int LINE_LVL_BIT = 7;
	localparam int AUX_LVL_BIT = 6;
	localparam int DRV_FAULT_BIT = 4;
	localparam int SUP_WARN_BIT = 3;
	localparam int SUP_UV_BIT = 2;
	localparam int THERM_SD_BIT = 1;
	localparam int THERM_WARN_BIT = 0;
	localparam int CORRUPT_BIT = 7;
	localparam int SW_RESET_BIT = 7;
	localparam logic [7:0] INTEGRITY_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [1:0] CLKDIV_RESET = 2'h0;

	typedef struct packed {
		logic line_low;
		logic aux_low;
		logic drv_fault;
		logic sup_warn;
		logic sup_uv;
		logic therm_sd;
		logic therm_warn;
		logic corrupt;
	} monitor_t;

	typedef struct packed {
		logic drv_enable;
		logic rx_oe;
		logic line_ind_oe;
		logic reg33_force;
		logic clk_out_en;
	} override_t;
endpackage : xcvr_status_pkg

// >>> rtl/mon_sync.sv
// two flip-flop synchroniser for the analog monitor inputs
// assumes the inputs are asynchronous levels
`timescale 1ns/1ps
module mon_sync
	import xcvr_status_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire monitor_t async_in,
	output monitor_t sync_out
);
	monitor_t meta_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : mon_sync

// >>> tb/host_model.sv
// host model driving the register port of the status group
// assumes the bench calls its tasks; drives just after rising edges
`timescale 1ns/1ps
module host_model
	import xcvr_status_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// released lines show the inverse, not the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= dat;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~dat;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] dat);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge sys_clk);
		#1 dat = reg_rdata;
	endtask : rd
	task automatic soft_reset();
		wr(SW_RESET_CTRL_OFS, 8'h80);
	endtask : soft_reset
endmodule : host_model

// >>> tb/tb.sv
// self-checking bench for the transceiver status and mode register group
// assumes host_model on the register port and random monitor levels
`timescale 1ns/1ps
module tb;
	import xcvr_status_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic corrupt_in = 1'b0;
	logic [6:0] mon = 7'h00;
	logic reg_wr, reg_rd, line_drv_en, rx_oe, li_oe, reg33_on, clk_en, clk_out, sr_pulse, c0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, r, d;
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	always #5 sys_clk = ~sys_clk;
	host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	xcvr_status_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.line_pin(mon[6]), .aux_pin(mon[5]), .drv_fault_in(mon[4]), .sup_warn_in(mon[3]),
		.sup_uv_in(mon[2]), .therm_sd_in(mon[1]), .therm_warn_in(mon[0]),
		.corrupt_in(corrupt_in), .line_drv_en(line_drv_en), .rx_oe(rx_oe),
		.line_indicator_output_oe(li_oe), .reg33_force_on(reg33_on), .clk_out_en(clk_en),
		.clk_out(clk_out), .soft_reset_pulse(sr_pulse));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [7:0] exp_live(input logic [6:0] m);
		return {~m[6:5], 1'b0, m[4:0]};
	endfunction : exp_live
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic test_done();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done
	task automatic soft_rst(input logic [7:0] integ);
		host.soft_reset();
		n = 0;
		while (sr_pulse !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk("pulse delay", 8'h01, 8'(n));
		if (n == 8) test_done();
		@(posedge sys_clk);
		#1 chk("pulse end", 8'h00, {7'h00, sr_pulse});
		host.rd(INTEGRITY_STATUS_OFS, d);
		chk("integrity", integ, d);
	endtask : soft_rst
	initial begin
		r = 8'h35;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 14; i++) begin
			@(posedge sys_clk);
			mon <= (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : {r[7:6], r[4:0]};
			r = lfsr(r);
			repeat (3) @(posedge sys_clk);
			host.rd(LIVE_STATUS_OFS, d);
			chk("live status", exp_live(mon), d);
		end
		host.rd(SW_RESET_CTRL_OFS, d);
		chk("mode read", 8'h00, d);
		host.rd(8'h07, d);
		chk("unmapped", 8'h00, d);
		host.wr(LIVE_STATUS_OFS, 8'hFF);
		host.wr(SW_RESET_CTRL_OFS, 8'h7F);
		repeat (3) begin
			@(posedge sys_clk);
			#1 chk("no reset pulse", 8'h00, {7'h00, sr_pulse});
		end
		host.rd(LIVE_STATUS_OFS, d);
		chk("live after write", exp_live(mon), d);
		soft_rst(8'h00);
		@(posedge sys_clk);
		corrupt_in <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 chk("overrides", 8'h06, {2'h0, line_drv_en, rx_oe, li_oe, reg33_on, clk_en, 1'b0});
		c0 = clk_out;
		@(posedge sys_clk);
		#1 chk("clk toggle", {7'h00, ~c0}, {7'h00, clk_out});
		soft_rst(8'h80);
		@(posedge sys_clk);
		corrupt_in <= 1'b0;
		repeat (6) @(posedge sys_clk);
		#1 chk("released", 8'h38, {2'h0, line_drv_en, rx_oe, li_oe, reg33_on, clk_en, clk_out});
		host.rd(INTEGRITY_STATUS_OFS, d);
		chk("integrity clear", 8'h00, d);
		test_done();
	end
endmodule : tb
